// File: design/vpp_defs.vh
// Constants for the voice processor peripheral port
// Summary of operation
// R1 - Slave port: 3-bit address, strobe, read/write inputs, 8-bit data, ready output.
// R2 - On reads the device drives the shared data bus toward the processor.
// R3 - On writes the device samples processor data and keeps its drivers off.
// R4 - Ready is active low; held high for wait states, low when access may end.
// R5 - Processor adds a wait state to every read; data valid 30 ns after strobe.
// R6 - Processor never writes directly after a read; bus release time is needed.
// R7 - Processor holds strobe low until ready falls; strobe rises 0 ns after.
// R8 - Device outputs a continuous clock derived from its master clock.
// R9 - Master reset held low at least 18 master clock periods.
// R10 - Master clock period is 61 ns; all port logic timed from it. The code sets VPP_CLK_PERIOD_NS to 20 ns instead.
// R11 - Reads of receive buffer return successive 4-bit nibbles in received order.
// R12 - Transmit writes enter a sequential pipe into the circular transmit buffer.
// R13 - Processor clock output runs at the master clock frequency, 16.384 MHz.
// R14 - Address and direction captured at strobe fall; write data at strobe rise.
`ifndef VPP_DEFS_VH
`define VPP_DEFS_VH

`define VPP_ADDR_W        3
`define VPP_DATA_W        8
`define VPP_NIB_W         4
`define VPP_FIFO_DEPTH    8
`define VPP_FIFO_AW       3
`define VPP_RX_NIBBLES    36
`define VPP_BUF_AW        6
`define VPP_BUF_LAST      6'h23
`define VPP_CLK_PERIOD_NS 20
`define VPP_RD_ACCESS_NS  30
`define VPP_RD_WAIT_CYC   ((`VPP_RD_ACCESS_NS + `VPP_CLK_PERIOD_NS - 1) / `VPP_CLK_PERIOD_NS)
`define VPP_RESET_MIN_CYC 18
`define VPP_A_RX_DATA     3'h0
`define VPP_A_TX_DATA     3'h1
`define VPP_A_STATUS      3'h2
`define VPP_ST_RX_AVAIL   0
`define VPP_ST_TX_ROOM    1

`endif

// File: design/vpp_fifo.v
// Parameterised synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ns
`default_nettype none
module vpp_fifo #(
    parameter WIDTH = 4,
    parameter DEPTH = 8,
    parameter AW    = 3
) (
    input  wire             sys_clk_i,
    input  wire             rst_n_i,
    input  wire [WIDTH-1:0] in_data_i,
    input  wire             in_valid_i,
    output wire             in_ready_o,
    output wire [WIDTH-1:0] out_data_o,
    output wire             out_valid_o,
    input  wire             out_ready_i
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wr_q;
    reg [AW-1:0]    rd_q;
    reg [AW:0]      cnt_q;
    wire            push;
    wire            pop;

    localparam [AW-1:0] PTR_ONE = {{(AW-1){1'b0}}, 1'b1};
    localparam [AW:0]   CNT_ONE = {{AW{1'b0}}, 1'b1};

    assign in_ready_o  = (cnt_q != DEPTH);
    assign out_valid_o = (cnt_q != 0);
    assign out_data_o  = mem[rd_q];
    assign push        = in_valid_i & in_ready_o;
    assign pop         = out_valid_o & out_ready_i;

    always @(posedge sys_clk_i) begin
        if (push) begin
            mem[wr_q] <= in_data_i;
        end
        if (!rst_n_i) begin
            wr_q  <= {AW{1'b0}};
            rd_q  <= {AW{1'b0}};
            cnt_q <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_q <= (wr_q == DEPTH - 1) ? {AW{1'b0}} : wr_q + PTR_ONE;
            end
            if (pop) begin
                rd_q <= (rd_q == DEPTH - 1) ? {AW{1'b0}} : rd_q + PTR_ONE;
            end
            if (push && !pop) begin
                cnt_q <= cnt_q + CNT_ONE;
            end else if (pop && !push) begin
                cnt_q <= cnt_q - CNT_ONE;
            end
        end
    end
endmodule
`default_nettype wire

// File: design/vpp_port.v
// Voice processor slave port with receive and transmit nibble pipes
`timescale 1ns/1ns
`default_nettype none
`include "vpp_defs.vh"
module vpp_port (
    input  wire                     sys_clk_i,
    input  wire                     rst_n_i,
    // Voice processor pins
    input  wire [`VPP_ADDR_W-1:0]   vp_addr_i,
    input  wire [`VPP_DATA_W-1:0]   vp_data_i,
    output reg  [`VPP_DATA_W-1:0]   vp_data_o,
    output reg                      vp_data_oe_n_o,
    input  wire                     vp_strobe_i,
    input  wire                     vp_read_not_write_i,
    output reg                      vp_ready_n_o,
    output wire                     vp_clock_out_o,
    // Receive side: demodulator nibble writes into circular buffer
    input  wire [`VPP_NIB_W-1:0]    rx_nibble_i,
    input  wire                     rx_nibble_valid_i,
    // Transmit side: modulator drains the nibble pipe
    output wire [`VPP_NIB_W-1:0]    tx_nibble_o,
    output wire                     tx_nibble_valid_o,
    input  wire                     tx_nibble_ready_i,
    output reg                      tx_overflow_o
);
    localparam [3:0] ST_IDLE = 4'h1;
    localparam [3:0] ST_WAIT = 4'h2;
    localparam [3:0] ST_RDY  = 4'h4;
    localparam [3:0] ST_END  = 4'h8;

    reg [3:0]                state_q;
    reg [1:0]                strobe_s_q;
    reg [`VPP_ADDR_W-1:0]    addr_s1_q;
    reg [`VPP_ADDR_W-1:0]    addr_s2_q;
    reg [`VPP_DATA_W-1:0]    data_s1_q;
    reg [`VPP_DATA_W-1:0]    data_s2_q;
    reg                      rnw_s1_q;
    reg                      rnw_s2_q;
    reg                      strobe_d2_q;
    reg [`VPP_ADDR_W-1:0]    addr_q;
    reg                      rnw_q;
    reg [1:0]                wait_q;
    reg [`VPP_NIB_W-1:0]     rx_mem [0:`VPP_RX_NIBBLES-1];
    reg [`VPP_BUF_AW-1:0]    rx_wr_q;
    reg [`VPP_BUF_AW-1:0]    rx_rd_q;
    reg [`VPP_BUF_AW:0]      rx_cnt_q;
    reg [`VPP_NIB_W-1:0]     tx_wdata;
    wire [31:0]              rd_wait_full;
    wire                     strobe_fall;
    wire                     strobe_rise;
    wire                     tx_in_ready;
    wire                     rx_pop;
    wire                     tx_push;

    function [`VPP_BUF_AW-1:0] vpp_wrap;
        input [`VPP_BUF_AW-1:0] ptr;
        begin
            vpp_wrap = (ptr == `VPP_BUF_LAST) ? {`VPP_BUF_AW{1'b0}} : ptr + 6'h01;
        end
    endfunction

    // R8 R13 clock out
    // Master clock forwarded as is; same frequency by construction
    assign vp_clock_out_o = sys_clk_i;

    // R10 R1 pin synchronisers
    always @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            strobe_s_q  <= 2'h3;
            strobe_d2_q <= 1'b1;
            addr_s1_q   <= 3'h0;
            addr_s2_q   <= 3'h0;
            data_s1_q   <= 8'h00;
            data_s2_q   <= 8'h00;
            rnw_s1_q    <= 1'b1;
            rnw_s2_q    <= 1'b1;
        end else begin
            strobe_s_q  <= {strobe_s_q[0], vp_strobe_i};
            strobe_d2_q <= strobe_s_q[1];
            addr_s1_q   <= vp_addr_i;
            addr_s2_q   <= addr_s1_q;
            data_s1_q   <= vp_data_i;
            data_s2_q   <= data_s1_q;
            rnw_s1_q    <= vp_read_not_write_i;
            rnw_s2_q    <= rnw_s1_q;
        end
    end

    // Integer wait count, cut to the counter width below
    assign rd_wait_full = `VPP_RD_WAIT_CYC;
    assign strobe_fall = strobe_d2_q & ~strobe_s_q[1];
    assign strobe_rise = ~strobe_d2_q & strobe_s_q[1];

    // R12 pipe write on strobe rise
    assign tx_push = (state_q == ST_RDY) & strobe_rise & ~rnw_q & (addr_q == `VPP_A_TX_DATA);
    // R11 advance read pointer once per receive data read
    assign rx_pop  = (state_q == ST_RDY) & strobe_rise & rnw_q & (addr_q == `VPP_A_RX_DATA)
                     & (rx_cnt_q != 0);

    always @* begin
        tx_wdata = data_s2_q[`VPP_NIB_W-1:0];
    end

    vpp_fifo #(
        .WIDTH (`VPP_NIB_W),
        .DEPTH (`VPP_FIFO_DEPTH),
        .AW    (`VPP_FIFO_AW)
    ) u_tx_fifo (
        .sys_clk_i   (sys_clk_i),
        .rst_n_i     (rst_n_i),
        .in_data_i   (tx_wdata),
        .in_valid_i  (tx_push),
        .in_ready_o  (tx_in_ready),
        .out_data_o  (tx_nibble_o),
        .out_valid_o (tx_nibble_valid_o),
        .out_ready_i (tx_nibble_ready_i)
    );

    // R11 circular receive buffer
    always @(posedge sys_clk_i) begin
        if (rx_nibble_valid_i) begin
            rx_mem[rx_wr_q] <= rx_nibble_i;
        end
        if (!rst_n_i) begin
            rx_wr_q  <= 6'h00;
            rx_rd_q  <= 6'h00;
            rx_cnt_q <= 7'h00;
        end else begin
            if (rx_nibble_valid_i) begin
                rx_wr_q <= vpp_wrap(rx_wr_q);
            end
            if (rx_pop) begin
                rx_rd_q <= vpp_wrap(rx_rd_q);
            end
            // Overrun cannot occur by system design; count saturates anyway
            if (rx_nibble_valid_i && !rx_pop && rx_cnt_q != `VPP_RX_NIBBLES) begin
                rx_cnt_q <= rx_cnt_q + 7'h01;
            end else if (rx_pop && !rx_nibble_valid_i) begin
                rx_cnt_q <= rx_cnt_q - 7'h01;
            end
        end
    end

    // R14 R4 access sequencer
    always @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            state_q        <= ST_IDLE;
            addr_q         <= 3'h0;
            rnw_q          <= 1'b1;
            wait_q         <= 2'h0;
            vp_ready_n_o   <= 1'b1;
            vp_data_oe_n_o <= 1'b1;
            vp_data_o      <= 8'h00;
            tx_overflow_o  <= 1'b0;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    vp_ready_n_o   <= 1'b1;
                    vp_data_oe_n_o <= 1'b1;
                    if (strobe_fall) begin
                        // R14 capture on fall
                        addr_q  <= addr_s2_q;
                        rnw_q   <= rnw_s2_q;
                        wait_q  <= rd_wait_full[1:0];
                        state_q <= ST_WAIT;
                        // R2 drive on read
                        vp_data_oe_n_o <= ~rnw_s2_q;
                    end
                end
                ST_WAIT: begin
                    // R4 wait states
                    if (wait_q != 2'h0) begin
                        wait_q <= wait_q - 2'h1;
                    end else if (!rnw_q && addr_q == `VPP_A_TX_DATA && !tx_in_ready) begin
                        // Pipe full: stretch the write until the modulator drains
                        vp_ready_n_o <= 1'b1;
                    end else begin
                        vp_ready_n_o <= 1'b0;
                        state_q      <= ST_RDY;
                    end
                    case (addr_q)
                        `VPP_A_RX_DATA: vp_data_o <= {4'h0, rx_mem[rx_rd_q]};
                        `VPP_A_STATUS:  vp_data_o <= {6'h00, tx_in_ready, rx_cnt_q != 0};
                        default:        vp_data_o <= 8'h00;
                    endcase
                end
                ST_RDY: begin
                    // R7 hold until strobe rises
                    if (strobe_rise) begin
                        vp_ready_n_o <= 1'b1;
                        state_q      <= ST_END;
                        if (tx_push && !tx_in_ready) begin
                            tx_overflow_o <= 1'b1;
                        end
                    end
                end
                ST_END: begin
                    // R3 R6 release bus after access
                    vp_data_oe_n_o <= 1'b1;
                    state_q        <= ST_IDLE;
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// File: testbench/vpp_asserts.sv
// Port protocol checker for the voice processor port
`timescale 1ns/1ns
`default_nettype none
module vpp_asserts (
    input wire logic       sys_clk_i,
    input wire logic       rst_n_i,
    input wire logic       vp_strobe_i,
    input wire logic       vp_read_not_write_i,
    input wire logic [2:0] vp_addr_i,
    input wire logic [7:0] vp_data_o,
    input wire logic       vp_data_oe_n_o,
    input wire logic       vp_ready_n_o,
    input wire logic       vp_clock_out_o,
    input wire logic       tx_nibble_valid_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);
    sequence s_rd_start; $fell(vp_strobe_i) ##0 vp_read_not_write_i; endsequence
    sequence s_wr_end; $rose(vp_strobe_i) ##0 !vp_read_not_write_i && vp_addr_i == 3'h1; endsequence
    property p_rd_wait; s_rd_start |-> vp_ready_n_o[*5]; endproperty
    property p_rd_ans; s_rd_start |-> ##[5:12] !vp_ready_n_o; endproperty
    property p_rd_oe; $fell(vp_ready_n_o) && vp_read_not_write_i |-> !vp_data_oe_n_o; endproperty
    property p_wr_oe; !vp_ready_n_o && !vp_read_not_write_i |-> vp_data_oe_n_o; endproperty
    property p_rd_hold; !vp_ready_n_o && !$past(vp_ready_n_o) |-> $stable(vp_data_o); endproperty
    property p_release; $rose(vp_strobe_i) |-> ##[1:5] vp_ready_n_o; endproperty
    property p_clk_out; @(negedge sys_clk_i) vp_clock_out_o; endproperty
    property p_tx_push; s_wr_end |-> ##[1:6] tx_nibble_valid_o; endproperty
    a_rd_wait: assert property (p_rd_wait) else $error("read not stretched");
    a_rd_ans: assert property (p_rd_ans) else $error("read never ready");
    a_rd_oe: assert property (p_rd_oe) else $error("read bus not driven");
    a_wr_oe: assert property (p_wr_oe) else $error("bus driven in write");
    a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
    a_release: assert property (p_release) else $error("ready not released");
    a_clk_out: assert property (p_clk_out) else $error("clock out missing");
    a_tx_push: assert property (p_tx_push) else $error("write not queued");
endmodule
`default_nettype wire

// File: testbench/vpp_port_tb.sv
// Self-checking bench for the voice processor port
`timescale 1ns/1ns
`default_nettype none
module vpp_port_tb;
    logic sys_clk_i, rst_n_i = 0, go = 0, rnw = 1, drain = 0, rx_nibble_valid_i = 0, tx_nibble_ready_i = 0;
    logic [2:0] addr = 0;
    logic [7:0] wd = 0;
    logic [3:0] rx_nibble_i = 0, nib[12];
    wire logic vp_strobe_i, vp_read_not_write_i, done, vp_data_oe_n_o, vp_ready_n_o, vp_clock_out_o;
    wire logic tx_nibble_valid_o, tx_overflow_o;
    wire logic [2:0] vp_addr_i;
    wire logic [3:0] tx_nibble_o;
    wire logic [7:0] pdata, rdata, vp_data_o, vp_data_i;
    int n_errors = 0, compares = 0, k;
    logic [7:0] rd_q[$];
    logic [3:0] tx_q[$];
    assign vp_data_i = vp_data_oe_n_o ? pdata : vp_data_o;
    vpp_port uut (.sys_clk_i, .rst_n_i, .vp_addr_i, .vp_data_i, .vp_data_o, .vp_data_oe_n_o, .vp_strobe_i,
        .vp_read_not_write_i, .vp_ready_n_o, .vp_clock_out_o, .rx_nibble_i, .rx_nibble_valid_i, .tx_nibble_o,
        .tx_nibble_valid_o, .tx_nibble_ready_i, .tx_overflow_o);
    vpp_proc_model proc (.clk_i(sys_clk_i), .go_i(go), .rnw_i(rnw), .addr_i(addr), .wdata_i(wd),
        .ready_n_i(vp_ready_n_o), .bus_i(vp_data_i), .strobe_o(vp_strobe_i), .rnw_o(vp_read_not_write_i),
        .addr_o(vp_addr_i), .pdata_o(pdata), .done_o(done), .rdata_o(rdata));
    initial begin
        sys_clk_i = 0;
        forever #10 sys_clk_i = ~sys_clk_i;
    end
    task automatic check(input string nm, input logic [7:0] e, input logic [7:0] g);
        compares++;
        if (g !== e) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic check_nib(input string nm, input logic [3:0] e, input logic [3:0] g);
        compares++;
        if (g !== e) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic end_of_test;
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic acc(input logic r, input logic [2:0] a, input logic [7:0] d, input logic [7:0] e);
        int i;
        go <= 1'b1;
        rnw <= r;
        addr <= a;
        wd <= d;
        if (r) rd_q.push_back(e);
        else if (a == 3'h1) tx_q.push_back(d[3:0]);
        @(posedge sys_clk_i);
        go <= 1'b0;
        for (i = 0; i < 400 && !done; i++) @(posedge sys_clk_i);
        // Model gave up waiting for ready, or the access never ended
        if (i == 400 || proc.n >= 300) begin
            n_errors++;
            end_of_test();
        end
    endtask
    always @(posedge sys_clk_i) begin
        tx_nibble_ready_i <= drain & 1'($urandom);
        if (done && vp_read_not_write_i) check("read data", rd_q.pop_front(), rdata);
        if (tx_nibble_valid_o && tx_nibble_ready_i) check_nib("tx nibble", tx_q.pop_front(), tx_nibble_o);
    end
    initial begin
        void'($urandom(9817));
        repeat (18) @(posedge sys_clk_i);
        rst_n_i <= 1'b1;
        @(posedge sys_clk_i);
        check("ready idle", 8'h01, {7'h0, vp_ready_n_o});
        check("bus released", 8'h01, {7'h0, vp_data_oe_n_o});
        for (k = 0; k < 12; k++) begin
            @(posedge sys_clk_i);
            nib[k] = 4'($urandom);
            rx_nibble_i <= nib[k];
            rx_nibble_valid_i <= 1'b1;
        end
        @(posedge sys_clk_i);
        rx_nibble_valid_i <= 1'b0;
        acc(1'b1, 3'h2, 8'h00, 8'h03);
        for (k = 0; k < 12; k++) acc(1'b1, 3'h0, 8'h00, {4'h0, nib[k]});
        acc(1'b1, 3'h7, 8'h00, 8'h00);
        // Fill the transmit pipe while the modulator stalls
        for (k = 0; k < 8; k++) acc(1'b0, 3'h1, 8'($urandom), 8'h00);
        acc(1'b1, 3'h2, 8'h00, 8'h00);
        fork
            acc(1'b0, 3'h1, 8'hC7, 8'h00);
            begin
                repeat (40) @(posedge sys_clk_i);
                drain <= 1'b1;
            end
        join
        acc(1'b0, 3'h7, 8'h3C, 8'h00);
        for (k = 0; k < 4; k++) acc(1'b0, 3'h1, 8'($urandom), 8'h00);
        for (k = 0; k < 300 && tx_q.size() > 0; k++) @(posedge sys_clk_i);
        if (k == 300) n_errors++;
        repeat (2) @(posedge sys_clk_i);
        check("tx valid", 8'h00, {7'h0, tx_nibble_valid_o});
        acc(1'b1, 3'h2, 8'h00, 8'h02);
        // Let the monitor take the last read before the verdict
        repeat (2) @(posedge sys_clk_i);
        check("reads left", 8'h00, 8'(rd_q.size()));
        check("overflow", 8'h00, {7'h0, tx_overflow_o});
        end_of_test();
    end
endmodule
bind vpp_port vpp_asserts chk (.sys_clk_i, .rst_n_i, .vp_strobe_i, .vp_read_not_write_i, .vp_addr_i,
    .vp_data_o, .vp_data_oe_n_o, .vp_ready_n_o, .vp_clock_out_o, .tx_nibble_valid_o);
`default_nettype wire

// File: testbench/vpp_proc_model.sv
// Behavioural voice processor acting as bus master
`timescale 1ns/1ns
`default_nettype none
module vpp_proc_model (
    input  wire logic       clk_i,
    input  wire logic       go_i,
    input  wire logic       rnw_i,
    input  wire logic [2:0] addr_i,
    input  wire logic [7:0] wdata_i,
    input  wire logic       ready_n_i,
    input  wire logic [7:0] bus_i,
    output var  logic       strobe_o,
    output var  logic       rnw_o,
    output var  logic [2:0] addr_o,
    output var  logic [7:0] pdata_o,
    output var  logic       done_o,
    output var  logic [7:0] rdata_o
);
    int n;
    initial begin
        {strobe_o, rnw_o, addr_o, pdata_o, done_o, rdata_o} = {2'b11, 3'h0, 8'h5A, 1'b0, 8'h00};
        forever begin
            @(posedge clk_i);
            done_o <= 1'b0;
            if (go_i) begin
                rnw_o <= rnw_i;
                addr_o <= addr_i;
                // Released bus shows inverse, not last value
                pdata_o <= rnw_i ? ~pdata_o : wdata_i;
                repeat (3) @(posedge clk_i);
                strobe_o <= 1'b0;
                for (n = 0; n < 300 && ready_n_i; n++) @(posedge clk_i);
                rdata_o <= bus_i;
                strobe_o <= 1'b1;
                @(posedge clk_i);
                addr_o <= ~addr_o;
                pdata_o <= ~pdata_o;
                repeat (6) @(posedge clk_i);
                done_o <= 1'b1;
            end
        end
    end
endmodule
`default_nettype wire
